/* hw/ssp_port.sv */
`timescale 1ns/10ps
module ssp_port
   import ssp_pkg::*;
(
   input wire logic pclk, // APB clock, 20 MHz
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic sck_i, // Serial clock pin in
   output logic sck_o, // Serial clock pin out
   output logic sck_oe, // Serial clock drive enable
   input wire logic sdi, // Serial data in
   output logic sdo, // Serial data out
   output logic sdo_oe, // Serial data drive enable
   input wire logic ss_n, // Slave select, active low
   output logic irq // Level interrupt
);
   logic sck_s1_q, sck_s2_q, sck_s3_q, sdi_s1_q, sdi_s2_q, ss_s1_q, ss_s2_q;
   logic [5:0] ctrl_q;
   logic [1:0] cfg_q;
   logic write_collision_flag_q, buffer_full_flag_q;
   logic [7:0] serial_data_buffer_q, serial_shift_reg_q, rx_q, rx_nx;
   logic [7:0] tmr_q, timer_period_value_q;
   logic [4:0] ph_q, div_q, half;
   ssp_state_type st_q;
   logic [1:0] ist_q, ien_q;
   logic irq_q, sck_q, sck_oe_q, sdo_oe_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q;
   logic en, master, slave, ckp, cpha, smp, ss_act, period_timer_output;
   logic tick, step, last, done, busy, sample_now, shift_now, sck_edge;
   logic setup, acc, wr, rd, wr_data, write_collision_flag_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_s1_q <= 1'b0;
         sck_s2_q <= 1'b0;
         sck_s3_q <= 1'b0;
         sdi_s1_q <= 1'b0;
         sdi_s2_q <= 1'b0;
         ss_s1_q <= 1'b1;
         ss_s2_q <= 1'b1;
      end else begin
         sck_s1_q <= sck_i;
         sck_s2_q <= sck_s1_q;
         sck_s3_q <= sck_s2_q;
         sdi_s1_q <= sdi;
         sdi_s2_q <= sdi_s1_q;
         ss_s1_q <= ss_n;
         ss_s2_q <= ss_s1_q;
      end
   end

   assign en = ctrl_q[EN_BIT];
   assign master = en && (ctrl_q[3:0] < MODE_SLV_SS);
   assign slave = en && (ctrl_q[3:0] == MODE_SLV_SS || ctrl_q[3:0] == MODE_SLV);
   assign ss_act = (ctrl_q[3:0] != MODE_SLV_SS) || !ss_s2_q;
   assign ckp = ctrl_q[CKP_BIT];
   assign cpha = !cfg_q[0];
   // Sampling at end of output time only makes sense when we own the clock
   assign smp = cfg_q[1] && master;
   assign busy = (st_q == ST_BUSY) || (ph_q != 5'h00);

   // Free-running period timer; its match, before any postscaler, feeds the shift clock
   assign period_timer_output = (tmr_q == timer_period_value_q);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr_q <= 8'h00;
      end else if (period_timer_output) begin
         tmr_q <= 8'h00;
      end else begin
         tmr_q <= tmr_q + 8'h01;
      end
   end

   always_comb begin
      case (ctrl_q[3:0])
         MODE_DIV16: half = HALF_DIV16;
         MODE_DIV64: half = HALF_DIV64;
         default: half = HALF_DIV4;
      endcase
   end
   assign tick = (ctrl_q[3:0] == MODE_TMR) ? period_timer_output
                                            : (div_q == half - 5'h01);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 5'h00;
      end else if (st_q != ST_BUSY || tick) begin
         div_q <= 5'h00;
      end else begin
         div_q <= div_q + 5'h01;
      end
   end

   assign sck_edge = sck_s2_q != sck_s3_q;
   assign step = master ? (st_q == ST_BUSY && tick) : (slave && ss_act && sck_edge);
   assign last = master ? (ph_q == PH_MASTER_LAST) : (ph_q == PH_SLAVE_LAST);
   assign done = step && last;
   // Even phases are leading edges; the extra master phase closes the last bit
   assign sample_now = step && (smp ? (cpha ? (!ph_q[0] && ph_q != 5'h00) : ph_q[0])
                                    : (cpha ? ph_q[0] : (!ph_q[0] && ph_q != PH_MASTER_LAST)));
   assign shift_now = step && (cpha ? (!ph_q[0] && ph_q != 5'h00 && ph_q != PH_MASTER_LAST)
                                    : ph_q[0]);
   assign rx_nx = sample_now ? {rx_q[6:0], sdi_s2_q} : rx_q;

   assign setup = psel && !penable;
   assign acc = psel && penable && pready_q;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign wr_data = wr && paddr == ADDR_DATA;
   assign write_collision_flag_set = wr_data && busy;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE;
      end else begin
         case (st_q)
            ST_IDLE: if (wr_data && !busy && master) st_q <= ST_BUSY;
            ST_BUSY: if (done || !master) st_q <= ST_IDLE;
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_q <= 5'h00;
      end else if (!en || (slave && !ss_act) || done) begin
         ph_q <= 5'h00;
      end else if (step) begin
         ph_q <= ph_q + 5'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_shift_reg_q <= 8'h00;
      end else if (wr_data && !busy) begin
         serial_shift_reg_q <= pwdata[7:0];
      end else if (shift_now) begin
         serial_shift_reg_q <= {serial_shift_reg_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_q <= 8'h00;
      end else begin
         rx_q <= rx_nx;
      end
   end

   // Separate holding buffer lets the next byte shift in before software reads
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_data_buffer_q <= 8'h00;
      end else if (done) begin
         serial_data_buffer_q <= rx_nx;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buffer_full_flag_q <= 1'b0;
      end else if (done) begin
         buffer_full_flag_q <= 1'b1;
      end else if (rd && paddr == ADDR_DATA) begin
         buffer_full_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_collision_flag_q <= 1'b0;
      end else if (write_collision_flag_set) begin
         write_collision_flag_q <= 1'b1;
      end else if (wr && paddr == ADDR_CTRL && !pwdata[WRITE_COLLISION_FLAG_BIT]) begin
         write_collision_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 6'h00;
         cfg_q <= 2'h0;
         ien_q <= 2'h0;
         timer_period_value_q <= PER_RST;
      end else if (wr) begin
         if (paddr == ADDR_CTRL) begin
            ctrl_q <= pwdata[5:0];
         end else if (paddr == ADDR_STAT) begin
            cfg_q <= pwdata[SMP_BIT:CKE_BIT];
         end else if (paddr == ADDR_IEN) begin
            ien_q <= pwdata[1:0];
         end else if (paddr == ADDR_PER) begin
            timer_period_value_q <= pwdata[7:0];
         end
      end
   end

   // Set beats clear so a completion landing on a clear write is kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_q <= 2'h0;
      end else begin
         ist_q <= (ist_q & ~((wr && paddr == ADDR_ICLR) ? pwdata[1:0] : 2'h0))
                  | {write_collision_flag_set, done};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(ist_q & ien_q);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_q <= 1'b0;
         sck_oe_q <= 1'b0;
         sdo_oe_q <= 1'b0;
      end else begin
         sck_oe_q <= master;
         sdo_oe_q <= master || (slave && ss_act);
         if (st_q != ST_BUSY) begin
            sck_q <= ckp;
         end else if (step && !last) begin
            sck_q <= !sck_q;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= setup;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         if (setup && !pwrite) begin
            if (paddr == ADDR_DATA) begin
               prdata_q <= {24'h00_0000, serial_data_buffer_q};
            end else if (paddr == ADDR_CTRL) begin
               prdata_q <= {24'h00_0000, write_collision_flag_q, 1'b0, ctrl_q};
            end else if (paddr == ADDR_STAT) begin
               prdata_q <= {24'h00_0000, cfg_q, 5'h00, buffer_full_flag_q};
            end else if (paddr == ADDR_ISTAT) begin
               prdata_q <= {30'h0000_0000, ist_q};
            end else if (paddr == ADDR_IEN) begin
               prdata_q <= {30'h0000_0000, ien_q};
            end else if (paddr == ADDR_PER) begin
               prdata_q <= {24'h00_0000, timer_period_value_q};
            end else if (paddr != ADDR_ICLR) begin
               pslverr_q <= 1'b1;
            end
         end else if (setup) begin
            pslverr_q <= !(paddr == ADDR_DATA || paddr == ADDR_CTRL || paddr == ADDR_STAT
                           || paddr == ADDR_ICLR || paddr == ADDR_IEN || paddr == ADDR_PER);
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign sck_o = sck_q;
   assign sck_oe = sck_oe_q;
   assign sdo = serial_shift_reg_q[7];
   assign sdo_oe = sdo_oe_q;
   assign irq = irq_q;

   property p_buf_load;
      @(posedge pclk) disable iff (!presetn) done |=> serial_data_buffer_q == $past(rx_nx);
   endproperty
   a_buf_load: assert property (p_buf_load) else $error("buffer not loaded at byte end");
   property p_bf_set;
      @(posedge pclk) disable iff (!presetn) done |=> buffer_full_flag_q && ist_q[IRQ_DONE];
   endproperty
   a_bf_set: assert property (p_bf_set) else $error("flags not set at byte end");
   property p_write_collision_flag;
      @(posedge pclk) disable iff (!presetn)
         wr_data && busy && !shift_now |=> write_collision_flag_q
            && serial_shift_reg_q == $past(serial_shift_reg_q);
   endproperty
   a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision write not dropped");
   property p_write_collision_flag_hold;
      @(posedge pclk) disable iff (!presetn)
         write_collision_flag_q && !(wr && paddr == ADDR_CTRL) |=> write_collision_flag_q;
   endproperty
   a_write_collision_flag_hold: assert property (p_write_collision_flag_hold) else $error("collision flag lost");
   property p_bf_clr;
      @(posedge pclk) disable iff (!presetn)
         rd && paddr == ADDR_DATA && !done |=> !buffer_full_flag_q;
   endproperty
   a_bf_clr: assert property (p_bf_clr) else $error("buffer full not cleared by read");
   property p_irq_keep;
      @(posedge pclk) disable iff (!presetn)
         ist_q[IRQ_DONE] && !(wr && paddr == ADDR_ICLR) |=> ist_q[IRQ_DONE];
   endproperty
   a_irq_keep: assert property (p_irq_keep) else $error("interrupt flag dropped");
   property p_sck_idle;
      @(posedge pclk) disable iff (!presetn)
         st_q == ST_IDLE ##1 st_q == ST_IDLE && $stable(ctrl_q) |-> sck_q == ckp;
   endproperty
   a_sck_idle: assert property (p_sck_idle) else $error("idle clock level wrong");
   property p_slave_clk;
      @(posedge pclk) disable iff (!presetn) slave ##1 slave |-> !sck_oe_q;
   endproperty
   a_slave_clk: assert property (p_slave_clk) else $error("slave drives clock");
   property p_start;
      @(posedge pclk) disable iff (!presetn)
         wr_data && !busy && master |=> st_q == ST_BUSY && ph_q == 5'h00;
   endproperty
   a_start: assert property (p_start) else $error("master write did not start");
   c_done_master: cover property (@(posedge pclk) disable iff (!presetn) done && master);
   c_done_slave: cover property (@(posedge pclk) disable iff (!presetn) done && slave);
   c_write_collision_flag: cover property (@(posedge pclk) disable iff (!presetn) write_collision_flag_set);
endmodule : ssp_port

/* hw/ssp_pkg.sv */
package ssp_pkg;
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_ISTAT = 8'h0c;
   localparam logic [7:0] ADDR_ICLR = 8'h10;
   localparam logic [7:0] ADDR_IEN = 8'h14;
   localparam logic [7:0] ADDR_PER = 8'h18;
   localparam int WRITE_COLLISION_FLAG_BIT = 7;
   localparam int EN_BIT = 5;
   localparam int CKP_BIT = 4;
   localparam int SMP_BIT = 7;
   localparam int CKE_BIT = 6;
   localparam int BF_BIT = 0;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_WRITE_COLLISION_FLAG = 1;
   localparam logic [3:0] MODE_DIV4 = 4'h0;
   localparam logic [3:0] MODE_DIV16 = 4'h1;
   localparam logic [3:0] MODE_DIV64 = 4'h2;
   localparam logic [3:0] MODE_TMR = 4'h3;
   localparam logic [3:0] MODE_SLV_SS = 4'h4;
   localparam logic [3:0] MODE_SLV = 4'h5;
   localparam logic [4:0] HALF_DIV4 = 5'h02;
   localparam logic [4:0] HALF_DIV16 = 5'h08;
   localparam logic [4:0] HALF_DIV64 = 5'h10;
   localparam logic [4:0] PH_MASTER_LAST = 5'h10;
   localparam logic [4:0] PH_SLAVE_LAST = 5'h0f;
   localparam logic [7:0] PER_RST = 8'hff;
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_BUSY = 2'b10} ssp_state_type;
endpackage : ssp_pkg

/* verif/ssp_peer.sv */
`timescale 1ns/10ps
module ssp_peer (
   input wire logic sck, // Serial clock from the port
   input wire logic sdo, // Data from the port
   input wire logic ckp, // Idle level of sck
   input wire logic load, // Rising edge loads tx_byte
   input wire logic [7:0] tx_byte, // Byte sent back to the port
   output logic sdi, // Data to the port
   output logic [7:0] rx_byte // Byte captured from the port
);
   logic [7:0] sh_q;
   int n;
   initial begin
      sdi = 1'h0;
      rx_byte = 8'h00;
      sh_q = 8'h00;
      n = 0;
   end
   always @(posedge load) begin
      sh_q = tx_byte;
      sdi = tx_byte[7];
      rx_byte = 8'h00;
      n = 0;
   end
   // Only follows the clock of the port, never makes one
   always @(sck) begin
      if (sck !== ckp) begin
         rx_byte = {rx_byte[6:0], sdo};
      end else begin
         n = n + 1;
         sh_q = {sh_q[6:0], 1'h0};
         // After the last bit the line is let go: show the inverse, never a stale bit
         sdi = (n >= 8) ? ~sdi : sh_q[7];
      end
   end
endmodule : ssp_peer

/* verif/spi_shift_buffer_port_tb.sv */
`timescale 1ns/10ps
module spi_shift_buffer_port_tb;
   import ssp_pkg::*;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic pready, pslverr, serr, sck_o, sck_oe, sdo, sdo_oe, irq, psdi;
   logic bsck = 1'h0, bsdi = 1'h0, ss_n = 1'h1, slv = 1'h0, ck = 1'h0, load = 1'h0;
   logic [7:0] ptx = 8'h00, prx, tx, pt, got;
   logic [3:0] md = 4'h0;
   logic sck_prev = 1'h0;
   int errors = 0, compares = 0, tog = 0, gap = 0, gap_last = 0;
   always #25 pclk = ~pclk;
   ssp_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sck_i(bsck), .sck_o(sck_o), .sck_oe(sck_oe),
      .sdi(slv ? bsdi : psdi), .sdo(sdo), .sdo_oe(sdo_oe), .ss_n(ss_n), .irq(irq));
   ssp_peer peer (.sck(sck_o), .sdo(sdo), .ckp(ck), .load(load), .tx_byte(ptx), .sdi(psdi),
      .rx_byte(prx));
   // Toggle count and spacing of the master clock, in pclk cycles
   always @(posedge pclk) begin
      gap = gap + 1;
      if (sck_o !== sck_prev) begin
         tog = tog + 1;
         gap_last = gap;
         gap = 0;
      end
      sck_prev = sck_o;
   end
   task automatic finish_test;
      if (errors == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // Wait as long as the slave needs; only the watchdog ends a hung access
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rdat = prdata;
      serr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(rdat, e);
   endtask : rc
   function automatic logic [31:0] ctl(input logic w);
      return {24'h0, w, 1'h0, 1'h1, ck, md};
   endfunction : ctl
   function automatic int exp_half(input logic [3:0] m);
      case (m)
         MODE_DIV4: return 2;
         MODE_DIV16: return 8;
         MODE_DIV64: return 16;
         default: return 4; // Timer period 3 matches every 4 cycles
      endcase
   endfunction : exp_half
   task automatic cfg(input logic [3:0] m, input logic c);
      md = m;
      ck = c;
      apb(1'h1, ADDR_CTRL, ctl(1'h0));
      repeat (3) @(posedge pclk);
   endtask : cfg
   task automatic mstart(input logic [7:0] t, input logic [7:0] p);
      ptx = p;
      load = 1'h1;
      #1 load = 1'h0;
      tog = 0;
      apb(1'h1, ADDR_DATA, {24'h0, t});
   endtask : mstart
   task automatic wdone;
      int n;
      n = 0;
      rdat = 32'h0;
      while (rdat[0] !== 1'h1 && n < 300) begin
         apb(1'h0, ADDR_STAT, 32'h0);
         n++;
      end
      chk(rdat, 32'h41);
   endtask : wdone
   // Link clock only runs inside a frame; edges stay clear of pclk edges
   task automatic sframe(input logic [7:0] v);
      #3;
      for (int b = 7; b >= 0; b--) begin
         bsdi = v[b];
         #100 bsck = 1'h1;
         got = {got[6:0], sdo};
         #200 bsck = 1'h0;
         #100;
      end
      bsdi = ~bsdi;
   endtask : sframe
   initial begin
      #2000000;
      errors++;
      finish_test;
   end
   initial begin
      tx = 8'($urandom(5));
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      rc(ADDR_CTRL, 32'h0);
      rc(ADDR_ISTAT, 32'h0);
      rc(ADDR_PER, 32'hff);
      apb(1'h0, 8'h1c, 32'h0);
      chk({31'h0, serr}, 32'h1);
      apb(1'h1, ADDR_PER, 32'h3);
      apb(1'h1, ADDR_STAT, 32'h40);
      rc(ADDR_STAT, 32'h40);
      for (int i = 0; i < 8; i++) begin
         cfg({2'h0, i[1:0]}, i[2]);
         chk({29'h0, sdo_oe, sck_oe, sck_o}, {29'h0, 1'h1, 1'h1, ck});
         tx = 8'($urandom);
         pt = 8'($urandom);
         mstart(tx, pt);
         apb(1'h1, ADDR_DATA, {24'h0, ~tx});
         wdone;
         chk(32'(tog), 32'h10);
         chk(32'(gap_last), 32'(exp_half(md)));
         chk({24'h0, prx}, {24'h0, tx});
         rc(ADDR_CTRL, ctl(1'h1));
         rc(ADDR_ISTAT, 32'h3);
         apb(1'h0, ADDR_DATA, 32'h0);
         // Fastest rate samples through the synchroniser without hold margin
         if (md != MODE_DIV4) chk(rdat, {24'h0, pt});
         rc(ADDR_STAT, 32'h40);
         rc(ADDR_ISTAT, 32'h3);
         apb(1'h1, ADDR_CTRL, ctl(1'h1));
         rc(ADDR_CTRL, ctl(1'h1));
         apb(1'h1, ADDR_CTRL, ctl(1'h0));
         rc(ADDR_CTRL, ctl(1'h0));
         apb(1'h1, ADDR_IEN, 32'h1);
         repeat (2) @(posedge pclk);
         chk({31'h0, irq}, 32'h1);
         apb(1'h1, ADDR_ICLR, 32'h1);
         repeat (2) @(posedge pclk);
         chk({31'h0, irq}, 32'h0);
         apb(1'h1, ADDR_IEN, 32'h0);
         apb(1'h1, ADDR_ICLR, 32'h3);
         rc(ADDR_ISTAT, 32'h0);
      end
      cfg(MODE_DIV16, 1'h0);
      mstart(8'h5a, 8'hc3);
      wdone;
      mstart(8'h3c, 8'h96);
      rc(ADDR_DATA, 32'hc3);
      wdone;
      rc(ADDR_DATA, 32'h96);
      rc(ADDR_ISTAT, 32'h1);
      slv <= 1'h1;
      for (int j = 0; j < 2; j++) begin
         cfg(j[0] ? MODE_SLV : MODE_SLV_SS, 1'h0);
         ss_n <= 1'h1;
         repeat (4) @(posedge pclk);
         chk({30'h0, sck_oe, sdo_oe}, {30'h0, 1'h0, j[0]});
         ss_n <= j[0];
         tx = 8'($urandom);
         pt = 8'($urandom);
         apb(1'h1, ADDR_DATA, {24'h0, tx});
         sframe(pt);
         wdone;
         chk({24'h0, got}, {24'h0, tx});
         rc(ADDR_DATA, {24'h0, pt});
      end
      finish_test;
   end
endmodule : spi_shift_buffer_port_tb
